// ### rtl/lhri_top.v
/*
 * LIN host register interface: direct SFRs (config, pointer, window) and
 * the fifteen indirect core registers with their mode gating and error handling.
 * Assumes the protocol engine sits outside on CLK and reports events as pulses.
 */
`include "lhri_map.vh"
`default_nettype none
module lhri_top (
	input wire CLK, // system clock 50 MHz
	input wire RST_B, // async reset, active low
	input wire [7:0] SFR_ADDR, // SFR address
	input wire [7:0] SFR_PAGE, // current SFR page
	input wire [7:0] SFR_WDATA, // write data
	input wire SFR_WR, // write strobe, one cycle
	input wire SFR_RD, // read strobe, one cycle
	output reg [7:0] SFR_RDATA, // read data, registered
	output wire SFR_HIT, // address decodes here
	input wire CORE_DONE, // frame or wake finished
	input wire CORE_ERR, // protocol error pulse
	input wire [4:0] CORE_ERR_KIND, // error flag bits with CORE_ERR
	input wire CORE_DATA_REQ, // slave identifier received
	input wire CORE_WAKEUP, // wake signal seen on bus
	input wire CORE_IDLTOUT, // bus idle timeout
	input wire CORE_ABORT, // slave frame aborted
	input wire CORE_ACTIVE, // bus active level
	input wire CORE_ACK_TAKEN, // core consumed data acknowledge
	input wire CORE_WAKE_SENT, // core consumed wake request
	input wire CORE_WR, // core writes a received byte
	input wire [2:0] CORE_WIDX, // data byte index of that write
	input wire [7:0] CORE_WDATA, // received byte
	input wire [5:0] CORE_RX_ID, // identifier received in slave mode
	output wire LIN_ENABLE, // controller enabled
	output wire LIN_MASTER, // master role
	output wire LIN_AUTOBAUD, // automatic baud active
	output wire START_FRAME, // start master frame, level
	output wire WAKE_REQ, // send wake signal, level
	output wire STOP_PULSE, // stop processing, one cycle
	output wire ABANDON_FRAME, // abandon current frame
	output wire DATA_ACK, // slave data acknowledge, level
	output wire SLEEP_MODE, // slave sleep
	output wire TX_DIR, // frame is transmit
	output wire IRQ, // interrupt request
	output wire [63:0] DATA_BYTES, // data buffer, byte 1 lowest
	output wire [7:0] FRAME_SIZE, // length and checksum type
	output wire [7:0] BAUD_DIV, // divider low byte
	output wire [7:0] BAUD_MUL, // multiplier and prescale
	output wire [5:0] FRAME_ID // identifier
);
	reg [7:0] interface_config;
	reg [7:0] indirect_pointer;
	reg [7:0] data_buffer [0:7];
	reg [7:0] frame_length_checksum;
	reg [7:0] baud_divider_low;
	reg [7:0] baud_multiplier_prescale;
	reg [7:0] frame_identifier;
	reg sleep_bit;
	reg txrx_bit;
	reg data_acknowledge;
	reg wake_signal_request;
	reg start_frame_request;
	reg [4:0] error_flags;
	reg stop_q;
	wire [7:0] link_status;
	wire [7:0] st_flags;
	wire [7:0] st_set;
	wire [7:0] st_clr;
	wire master;
	wire sel_cfg;
	wire sel_win;
	wire sel_ptr;
	wire win_wr;
	wire clear_error_cmd;
	wire clear_int_cmd;
	wire [7:0] err_set_mask;
	reg [7:0] ind_read;
	integer k;

	// Pages are kept apart so a config write never aliases the LIN page
	assign sel_cfg = (SFR_ADDR == `LHRI_SFR_CONFIG) && (SFR_PAGE == `LHRI_PAGE_CONFIG); // [R11]
	assign sel_win = (SFR_ADDR == `LHRI_SFR_WINDOW) && (SFR_PAGE == `LHRI_PAGE_LIN); // [R11]
	assign sel_ptr = (SFR_ADDR == `LHRI_SFR_POINTER) && (SFR_PAGE == `LHRI_PAGE_LIN); // [R11]
	assign SFR_HIT = sel_cfg | sel_win | sel_ptr;
	assign win_wr = SFR_WR & sel_win;
	assign master = interface_config[`LHRI_CFG_MASTER];

	// Pointer match, shared by the window write decodes of indices 0x08 and 0x0B to 0x0E
	function is_idx;
		input [7:0] ptr;
		input [7:0] idx;
		begin
			is_idx = (ptr == idx);
		end
	endfunction

	// Command bits act on the write itself and are never stored
	assign clear_error_cmd = win_wr & is_idx(indirect_pointer, `LHRI_IDX_CTRL)
		& SFR_WDATA[`LHRI_CTL_CLR_ERR]; // [R2] [R15]
	assign clear_int_cmd = win_wr & is_idx(indirect_pointer, `LHRI_IDX_CTRL)
		& SFR_WDATA[`LHRI_CTL_RSTINT];

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			interface_config <= `LHRI_CFG_RESET;
			indirect_pointer <= 8'h00;
		end else begin
			if (SFR_WR & sel_cfg)
				interface_config <= SFR_WDATA & `LHRI_CFG_RW_MASK; // [R7] [R8] [R9] [R10]
			if (SFR_WR & sel_ptr)
				indirect_pointer <= SFR_WDATA; // [R4] [R17]
		end
	end

	// Auto baud is forced off in master mode whatever the stored bit says
	assign LIN_ENABLE = interface_config[`LHRI_CFG_EN]; // [R7]
	assign LIN_MASTER = master; // [R8]
	assign LIN_AUTOBAUD = interface_config[`LHRI_CFG_AUTO_BAUD] & ~master; // [R9]

	// Status flags: set from core events, error and int cleared by commands
	assign st_set[7] = 1'b0;
	assign st_set[`LHRI_ST_IDLTOUT] = CORE_IDLTOUT & ~master;
	assign st_set[`LHRI_ST_ABORT] = CORE_ABORT & ~master; // [R14]
	assign st_set[`LHRI_ST_DATA_REQ] = CORE_DATA_REQ & ~master; // [R14]
	assign st_set[`LHRI_ST_INT] = CORE_DONE | CORE_ERR | CORE_DATA_REQ | CORE_IDLTOUT
		| CORE_WAKEUP; // [R1]
	assign st_set[`LHRI_ST_ERROR] = CORE_ERR; // [R1]
	assign st_set[`LHRI_ST_WAKEUP] = CORE_WAKEUP;
	assign st_set[`LHRI_ST_DONE] = CORE_DONE | CORE_WAKEUP;
	// Clears come only from command bits and the consumed acknowledge
	assign st_clr[7] = 1'b0;
	assign st_clr[`LHRI_ST_IDLTOUT] = clear_int_cmd;
	assign st_clr[`LHRI_ST_ABORT] = clear_error_cmd; // [R15]
	assign st_clr[`LHRI_ST_DATA_REQ] = data_acknowledge & CORE_ACK_TAKEN;
	assign st_clr[`LHRI_ST_INT] = clear_int_cmd;
	assign st_clr[`LHRI_ST_ERROR] = clear_error_cmd; // [R15]
	assign st_clr[`LHRI_ST_WAKEUP] = clear_int_cmd;
	assign st_clr[`LHRI_ST_DONE] = clear_int_cmd;

	lhri_event_flags u_flags (
		.CLK(CLK),
		.RST_B(RST_B),
		.set_evt(st_set),
		.clr_evt(st_clr),
		.flags(st_flags)
	);

	// Bus activity is a live level, not a stored flag
	assign link_status = {CORE_ACTIVE, st_flags[6:0]};
	assign IRQ = st_flags[`LHRI_ST_INT]; // [R1]
	assign ABANDON_FRAME = CORE_ERR; // [R1]

	// Slave-only error bits are masked in master mode
	assign err_set_mask = master ? (`LHRI_ERR_ALL_MASK & ~`LHRI_ERR_SLAVE_MASK)
		: `LHRI_ERR_ALL_MASK; // [R14]

	// A new error in the clear cycle wins so no cause is lost
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			error_flags <= 5'h00;
		end else if (CORE_ERR) begin
			error_flags <= error_flags | (CORE_ERR_KIND & err_set_mask[4:0]); // [R1]
		end else if (clear_error_cmd) begin
			error_flags <= 5'h00; // [R2] [R15]
		end
	end

	// Core writes win so a received byte is never lost to firmware
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (k = 0; k < 8; k = k + 1)
				data_buffer[k] <= 8'h00;
			frame_length_checksum <= 8'h00;
			baud_divider_low <= 8'h00;
			baud_multiplier_prescale <= 8'h00;
			frame_identifier <= 8'h00;
		end else begin
			if (CORE_WR)
				data_buffer[CORE_WIDX] <= CORE_WDATA;
			else if (win_wr && indirect_pointer <= `LHRI_IDX_DATA_LAST)
				data_buffer[indirect_pointer[2:0]] <= SFR_WDATA; // [R6] [R12]
			if (win_wr & is_idx(indirect_pointer, `LHRI_IDX_SIZE))
				frame_length_checksum <= SFR_WDATA & `LHRI_SIZE_MASK; // [R6]
			if (win_wr & is_idx(indirect_pointer, `LHRI_IDX_DIV))
				baud_divider_low <= SFR_WDATA; // [R6]
			if (win_wr & is_idx(indirect_pointer, `LHRI_IDX_MUL))
				baud_multiplier_prescale <= SFR_WDATA; // [R6]
			if (CORE_DATA_REQ & ~master)
				frame_identifier <= {2'b00, CORE_RX_ID};
			else if (win_wr & is_idx(indirect_pointer, `LHRI_IDX_ID))
				frame_identifier <= SFR_WDATA & `LHRI_ID_MASK; // [R6]
		end
	end

	// Control register; requests are held off while an error is pending
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sleep_bit <= 1'b0;
			txrx_bit <= 1'b0;
			data_acknowledge <= 1'b0;
			wake_signal_request <= 1'b0;
			start_frame_request <= 1'b0;
			stop_q <= 1'b0;
		end else begin
			// Stop acts for one cycle, and in slave mode only
			stop_q <= win_wr & is_idx(indirect_pointer, `LHRI_IDX_CTRL) & ~master
				& SFR_WDATA[`LHRI_CTL_STOP]; // [R14]
			if (win_wr & is_idx(indirect_pointer, `LHRI_IDX_CTRL)) begin
				txrx_bit <= SFR_WDATA[`LHRI_CTL_TXRX];
				if (!master)
					sleep_bit <= SFR_WDATA[`LHRI_CTL_SLEEP]; // [R14]
			end
			// Set wins; any other control write must not hide the core's take
			if (win_wr && is_idx(indirect_pointer, `LHRI_IDX_CTRL) && !master
				&& SFR_WDATA[`LHRI_CTL_DATA_ACK])
				data_acknowledge <= 1'b1; // [R14]
			else if (CORE_ACK_TAKEN)
				data_acknowledge <= 1'b0;
			if (CORE_WAKE_SENT | CORE_ERR)
				wake_signal_request <= 1'b0;
			else if (win_wr && is_idx(indirect_pointer, `LHRI_IDX_CTRL)
				&& SFR_WDATA[`LHRI_CTL_WAKE_REQ] && !st_flags[`LHRI_ST_ERROR])
				wake_signal_request <= 1'b1; // [R3]
			if (CORE_DONE | CORE_ERR | ~master)
				start_frame_request <= 1'b0; // [R16]
			else if (win_wr && is_idx(indirect_pointer, `LHRI_IDX_CTRL)
				&& SFR_WDATA[`LHRI_CTL_START_REQ] && !st_flags[`LHRI_ST_ERROR])
				start_frame_request <= 1'b1; // [R3] [R13]
		end
	end

	// Gated here too, so a request stored just before an error stops at once
	assign START_FRAME = start_frame_request & ~st_flags[`LHRI_ST_ERROR]; // [R3]
	assign WAKE_REQ = wake_signal_request & ~st_flags[`LHRI_ST_ERROR]; // [R3]
	assign STOP_PULSE = stop_q;
	assign DATA_ACK = data_acknowledge;
	assign SLEEP_MODE = sleep_bit;
	assign TX_DIR = txrx_bit;

	// Reads have no side effects on any flag
	always @* begin
		ind_read = 8'h00;
		if (indirect_pointer <= `LHRI_IDX_DATA_LAST)
			ind_read = data_buffer[indirect_pointer[2:0]]; // [R5] [R12]
		else case (indirect_pointer)
		`LHRI_IDX_CTRL: begin
			// Write-only command bits read as zero
			ind_read = {1'b0, sleep_bit & ~master, txrx_bit, data_acknowledge & ~master,
				1'b0, 1'b0, wake_signal_request, start_frame_request & master}; // [R13] [R14] [R15]
		end
		`LHRI_IDX_STATUS: begin
			// Slave-only flags read zero in master mode
			ind_read = master ? (link_status & ~`LHRI_ST_SLAVE_MASK) : link_status; // [R14]
		end
		`LHRI_IDX_ERR: begin
			ind_read = {3'b000, error_flags & err_set_mask[4:0]}; // [R14]
		end
		`LHRI_IDX_SIZE: begin
			ind_read = frame_length_checksum;
		end
		`LHRI_IDX_DIV: begin
			ind_read = baud_divider_low;
		end
		`LHRI_IDX_MUL: begin
			ind_read = baud_multiplier_prescale;
		end
		`LHRI_IDX_ID: begin
			ind_read = frame_identifier;
		end
		default: begin
			ind_read = 8'h00;
		end
		endcase
	end

	// Read data is registered and stands until the next read strobe
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			SFR_RDATA <= 8'h00;
		end else if (SFR_RD) begin
			if (sel_cfg)
				SFR_RDATA <= interface_config & `LHRI_CFG_RW_MASK; // [R10]
			else if (sel_ptr)
				SFR_RDATA <= indirect_pointer; // [R4]
			else if (sel_win)
				SFR_RDATA <= ind_read; // [R5]
			else
				SFR_RDATA <= 8'h00;
		end
	end

	// Byte 1 of the buffer sits in the low byte
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_bytes
			assign DATA_BYTES[g*8 +: 8] = data_buffer[g];
		end
	endgenerate
	assign FRAME_SIZE = frame_length_checksum;
	assign BAUD_DIV = baud_divider_low;
	assign BAUD_MUL = baud_multiplier_prescale;
	assign FRAME_ID = frame_identifier[5:0];
endmodule // lhri_top
`default_nettype wire

// ### rtl/lhri_map.vh
/*
 * Constants of the LIN host register interface: SFR addresses and pages,
 * indirect register indices, field positions and reset values.
 * Assumes a byte-wide SFR bus with separate read and write strobes.
 */
// Overview of operation
// (R1) On any protocol error the core abandons the frame and an interrupt request is raised.
// (R2) Firmware reads the error flags and writes 1 to clear_error_cmd, which clears the flags and the error status bit.
// (R3) No master frame start and no wake signal is issued while the error status bit is set.
// (R4) The pointer register at SFR 0xD3 holds an 8-bit index into the indirect registers.
// (R5) Reading the data window at SFR 0xD2 returns the indirect register that the pointer selects.
// (R6) Writing the data window stores the byte into the indirect register that the pointer selects.
// (R7) Configuration bit 7 enables the controller.
// (R8) Configuration bit 6 selects master (1) or slave (0).
// (R9) Configuration bit 5 selects automatic baud and only acts in slave mode.
// (R10) Configuration bits 4:0 read as zero and ignore writes.
// (R11) The configuration register decodes at 0xC9 on page 0x0F, pointer and window on page 0x00.
// (R12) Fifteen indirect registers sit at indices 0x00 to 0x0E.
// (R13) Master-only bits such as start_frame_request are reachable only in master mode.
// (R14) Slave-only bits are reachable only in slave mode; all other bits work in both. Here start_frame_request works in master mode only.
// (R15) clear_error_cmd clears error bits in status and error flags and always reads 0.
// (R16) start_frame_request clears itself on frame completion or on an error.
// (R17) The pointer does not auto-increment on window accesses.
`ifndef LHRI_MAP_VH
`define LHRI_MAP_VH

`define LHRI_SFR_CONFIG 8'hc9
`define LHRI_SFR_WINDOW 8'hd2
`define LHRI_SFR_POINTER 8'hd3
`define LHRI_PAGE_CONFIG 8'h0f
`define LHRI_PAGE_LIN 8'h00

`define LHRI_IDX_DATA_LAST 8'h07
`define LHRI_IDX_CTRL 8'h08
`define LHRI_IDX_STATUS 8'h09
`define LHRI_IDX_ERR 8'h0a
`define LHRI_IDX_SIZE 8'h0b
`define LHRI_IDX_DIV 8'h0c
`define LHRI_IDX_MUL 8'h0d
`define LHRI_IDX_ID 8'h0e

`define LHRI_CFG_RESET 8'h60
`define LHRI_CFG_EN 7
`define LHRI_CFG_MASTER 6
`define LHRI_CFG_AUTO_BAUD 5
`define LHRI_CFG_RW_MASK 8'he0

`define LHRI_CTL_STOP 7
`define LHRI_CTL_SLEEP 6
`define LHRI_CTL_TXRX 5
`define LHRI_CTL_DATA_ACK 4
`define LHRI_CTL_RSTINT 3
`define LHRI_CTL_CLR_ERR 2
`define LHRI_CTL_WAKE_REQ 1
`define LHRI_CTL_START_REQ 0

`define LHRI_ST_ACTIVE 7
`define LHRI_ST_IDLTOUT 6
`define LHRI_ST_ABORT 5
`define LHRI_ST_DATA_REQ 4
`define LHRI_ST_INT 3
`define LHRI_ST_ERROR 2
`define LHRI_ST_WAKEUP 1
`define LHRI_ST_DONE 0

`define LHRI_ERR_SLAVE_MASK 8'h18
`define LHRI_ST_SLAVE_MASK 8'h30
`define LHRI_ERR_ALL_MASK 8'h1f
`define LHRI_ID_MASK 8'h3f
`define LHRI_SIZE_MASK 8'h8f

`endif

// ### rtl/lhri_event_flags.v
/*
 * Sticky event flags of the LIN core status: set by core pulses,
 * cleared by firmware commands, set wins over clear in the same cycle.
 * Assumes events come from logic on CLK.
 */
`default_nettype none
module lhri_event_flags (
	input wire CLK, // system clock
	input wire RST_B, // async reset, active low
	input wire [7:0] set_evt, // one-cycle set pulses
	input wire [7:0] clr_evt, // one-cycle clear pulses
	output reg [7:0] flags // sticky flags
);
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_flag
			always @(posedge CLK or negedge RST_B) begin
				if (!RST_B)
					flags[i] <= 1'b0;
				else if (set_evt[i])
					flags[i] <= 1'b1;
				else if (clr_evt[i])
					flags[i] <= 1'b0;
			end
		end
	endgenerate
endmodule // lhri_event_flags
`default_nettype wire

// ### tb/lhri_props.sv
/* Checker on lhri_top ports: decode, config, error halting.
   Bound to every lhri_top instance below. */
`include "lhri_map.vh"
`default_nettype none
module lhri_props (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_PAGE,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_RDATA,
	input wire logic SFR_HIT,
	input wire logic CORE_DONE,
	input wire logic CORE_ERR,
	input wire logic ABANDON_FRAME,
	input wire logic IRQ,
	input wire logic START_FRAME,
	input wire logic WAKE_REQ,
	input wire logic LIN_ENABLE,
	input wire logic LIN_MASTER,
	input wire logic LIN_AUTOBAUD
);
	timeunit 1ns;
	timeprecision 1ps;
	wire cfg = SFR_ADDR == `LHRI_SFR_CONFIG && SFR_PAGE == `LHRI_PAGE_CONFIG;
	wire win = SFR_PAGE == `LHRI_PAGE_LIN && SFR_ADDR[7:1] == 7'h69;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_cfg_wr;
		SFR_WR && cfg;
	endsequence
	sequence s_cfg_new;
		LIN_ENABLE == $past(SFR_WDATA[7]) && LIN_MASTER == $past(SFR_WDATA[6]);
	endsequence
	a_hit_decode: assert property (SFR_HIT == (cfg || win))
		else $error("decode wrong");
	a_cfg_write: assert property (s_cfg_wr |=> s_cfg_new)
		else $error("config bits not taken");
	a_cfg_low: assert property (SFR_RD && cfg |=> SFR_RDATA[4:0] == 5'h00)
		else $error("config low bits set");
	a_baud_slave: assert property (LIN_AUTOBAUD |-> !LIN_MASTER)
		else $error("autobaud in master");
	a_abandon_err: assert property (ABANDON_FRAME == CORE_ERR)
		else $error("abandon not tied to error");
	a_err_irq: assert property (CORE_ERR |=> IRQ)
		else $error("no irq on error");
	a_err_halts: assert property (CORE_ERR |=> !START_FRAME && !WAKE_REQ)
		else $error("request survives error");
	a_done_ends: assert property (CORE_DONE |=> !START_FRAME)
		else $error("start not cleared");
	a_rdata_holds: assert property (!SFR_RD |=> $stable(SFR_RDATA))
		else $error("read data moved");
endmodule // lhri_props

bind lhri_top lhri_props i_props (.CLK, .RST_B, .SFR_ADDR, .SFR_PAGE, .SFR_WDATA,
	.SFR_WR, .SFR_RD, .SFR_RDATA, .SFR_HIT, .CORE_DONE, .CORE_ERR, .ABANDON_FRAME,
	.IRQ, .START_FRAME, .WAKE_REQ, .LIN_ENABLE, .LIN_MASTER, .LIN_AUTOBAUD);
`default_nettype wire

// ### tb/lhri_core_model.sv
/* Protocol engine stand-in: answers a start request with done or an error.
   Runs on the bench clock; the bench chooses failure. */
`default_nettype none
module lhri_core_model (
	input wire logic clk, // system clock
	input wire logic rst_b, // reset, active low
	input wire logic start, // start request level
	input wire logic fail, // report an error instead
	input wire logic [4:0] kind, // error bits to report
	output logic done, // frame finished pulse
	output logic err, // protocol error pulse
	output logic [4:0] err_kind // error bits with err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt;
	// Bits are driven only with the pulse, as a real engine would
	assign err_kind = err ? kind : 5'h00;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 3'h0;
			done <= 1'b0;
			err <= 1'b0;
		end else begin
			done <= 1'b0;
			err <= 1'b0;
			cnt <= (start && !done && !err) ? cnt + 3'h1 : 3'h0;
			if (cnt == 3'h3) begin
				done <= !fail;
				err <= fail;
			end
		end
	end
endmodule // lhri_core_model
`default_nettype wire

// ### tb/lhri_top_tb.sv
/* Self-checking bench of lhri_top with the engine stand-in.
   Drives the SFR bus and the core event inputs at falling edges, with one mid-run reset. */
`default_nettype none
module lhri_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, wr = 0, rd = 0, fail = 0;
	logic [7:0] addr = 0, page = 0, wdata = 0, rd_val;
	logic [4:0] kind = 5'h04;
	wire [7:0] rdata;
	wire hit, en, mst, auto_baud_select, start, wake, sleep, irq, done, err;
	wire [4:0] err_kind;
	logic data_req = 0, wakeup = 0, idle_to = 0, abort_evt = 0, active = 0;
	logic ack_taken = 0, wake_sent = 0, core_wr = 0;
	logic [2:0] widx = 0;
	logic [7:0] cwdata = 0;
	logic [5:0] rx_id = 0;
	wire stop, dack;
	wire [5:0] fid;
	wire [63:0] bytes;
	int num_errors = 0, num_checks = 0;
	// Pointer, written byte, read-back byte
	logic [23:0] rows [10] = '{24'h00a5a5, 24'h075a5a, 24'h0bff8f, 24'h0cffff,
		24'h0dffff, 24'h0eff3f, 24'h0aff00, 24'h09ff00, 24'h082020, 24'h0f5500};

	lhri_top i_dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_PAGE(page),
		.SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_HIT(hit),
		.CORE_DONE(done), .CORE_ERR(err), .CORE_ERR_KIND(err_kind),
		.CORE_DATA_REQ(data_req), .CORE_WAKEUP(wakeup), .CORE_IDLTOUT(idle_to),
		.CORE_ABORT(abort_evt), .CORE_ACTIVE(active), .CORE_ACK_TAKEN(ack_taken),
		.CORE_WAKE_SENT(wake_sent), .CORE_WR(core_wr), .CORE_WIDX(widx),
		.CORE_WDATA(cwdata), .CORE_RX_ID(rx_id), .LIN_ENABLE(en), .LIN_MASTER(mst),
		.LIN_AUTOBAUD(auto_baud_select), .START_FRAME(start), .WAKE_REQ(wake), .STOP_PULSE(stop),
		.ABANDON_FRAME(), .DATA_ACK(dack), .SLEEP_MODE(sleep), .TX_DIR(), .IRQ(irq),
		.DATA_BYTES(bytes), .FRAME_SIZE(), .BAUD_DIV(), .BAUD_MUL(), .FRAME_ID(fid));

	lhri_core_model i_core (.clk(clk), .rst_b(rst_b), .start(start), .fail(fail),
		.kind(kind), .done(done), .err(err), .err_kind(err_kind));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr_sfr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		page = p;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd_sfr(input logic [7:0] a, input logic [7:0] p);
		@(negedge clk);
		addr = a;
		page = p;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		rd_val = rdata;
	endtask

	task automatic wr_ind(input logic [7:0] i, input logic [7:0] d);
		wr_sfr(8'hd3, 8'h00, i);
		wr_sfr(8'hd2, 8'h00, d);
	endtask

	task automatic rd_ind(input logic [7:0] i);
		wr_sfr(8'hd3, 8'h00, i);
		rd_sfr(8'hd2, 8'h00);
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		forever #10 clk = ~clk;
	end

	// Whole run is a few hundred cycles
	initial begin
		#50us;
		num_errors++;
		end_of_test;
	end

	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		chk(8'(mst), 8'h01);
		rd_sfr(8'hc9, 8'h0f);
		chk(rd_val, 8'h60);
		rd_sfr(8'hd3, 8'h00);
		chk(rd_val, 8'h00);
		foreach (rows[k]) begin
			wr_ind(rows[k][23:16], rows[k][15:8]);
			rd_ind(rows[k][23:16]);
			chk(rd_val, rows[k][7:0]);
		end
		rd_sfr(8'hd3, 8'h00);
		chk(rd_val, 8'h0f);
		wr_sfr(8'hc9, 8'h00, 8'h00);
		chk(8'(mst), 8'h01);
		wr_sfr(8'hc9, 8'h0f, 8'hff);
		rd_sfr(8'hc9, 8'h0f);
		chk(rd_val, 8'he0);
		chk(8'({en, mst, auto_baud_select}), 8'h06);
		wr_sfr(8'hc9, 8'h0f, 8'ha0);
		chk(8'({en, mst, auto_baud_select}), 8'h05);
		wr_ind(8'h08, 8'h41);
		chk(8'({start, sleep}), 8'h01);
		wr_sfr(8'hc9, 8'h0f, 8'hc0);
		wr_ind(8'h08, 8'h01);
		chk(8'(start), 8'h01);
		repeat (10) @(negedge clk);
		chk(8'({start, irq}), 8'h01);
		fail = 1'b1;
		wr_ind(8'h08, 8'h01);
		repeat (10) @(negedge clk);
		chk(8'(start), 8'h00);
		rd_ind(8'h0a);
		chk(rd_val, 8'h04);
		wr_ind(8'h08, 8'h03);
		chk(8'({start, wake}), 8'h00);
		wr_sfr(8'hd2, 8'h00, 8'h04);
		rd_ind(8'h0a);
		chk(rd_val, 8'h00);
		rd_ind(8'h09);
		chk(8'(rd_val[2]), 8'h00);
		rd_ind(8'h08);
		chk(rd_val & 8'h0c, 8'h00);
		wr_sfr(8'hd2, 8'h00, 8'h02);
		chk(8'(wake), 8'h01);
		@(negedge clk);
		wake_sent = 1'b1;
		@(negedge clk);
		wake_sent = 1'b0;
		chk(8'(wake), 8'h00);
		// Second reset in mid-run: config, pointer and flags return to reset values
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		chk(8'({en, mst, irq}), 8'h02);
		rd_sfr(8'hd3, 8'h00);
		chk(rd_val, 8'h00);
		wr_sfr(8'hc9, 8'h0f, 8'h80);
		@(negedge clk);
		rx_id = 6'h2a;
		active = 1'b1;
		data_req = 1'b1;
		@(negedge clk);
		data_req = 1'b0;
		chk(8'(fid), 8'h2a);
		rd_ind(8'h09);
		chk(rd_val, 8'h98);
		wr_ind(8'h08, 8'h10);
		chk(8'(dack), 8'h01);
		@(negedge clk);
		ack_taken = 1'b1;
		@(negedge clk);
		ack_taken = 1'b0;
		chk(8'(dack), 8'h00);
		rd_ind(8'h09);
		chk(rd_val, 8'h88);
		widx = 3'h3;
		cwdata = 8'hc3;
		core_wr = 1'b1;
		@(negedge clk);
		core_wr = 1'b0;
		chk(bytes[31:24], 8'hc3);
		rd_ind(8'h03);
		chk(rd_val, 8'hc3);
		wr_ind(8'h08, 8'h80);
		chk(8'(stop), 8'h01);
		@(negedge clk);
		chk(8'(stop), 8'h00);
		wakeup = 1'b1;
		idle_to = 1'b1;
		abort_evt = 1'b1;
		@(negedge clk);
		wakeup = 1'b0;
		idle_to = 1'b0;
		abort_evt = 1'b0;
		rd_ind(8'h09);
		chk(rd_val, 8'heb);
		wr_ind(8'h08, 8'h0c);
		rd_ind(8'h09);
		chk(rd_val, 8'h80);
		end_of_test;
	end
endmodule // lhri_top_tb
`default_nettype wire
